/* shared/timer16_pkg.sv */
// Function
// - Flags register at 0x000 shows pending sources
// - Software writes clear pending flags
// - Bits 0-3 compare, bit 4 capture, W1C
// - Run-control register at 0x004
// - Bit 0 enables, bit 1 holds counters reset
// - 16-bit count advances every limit+1 cycles or selected edges
// - Divider at limit: count increments, divider clears
// - Divider count readable and writable
// - Compare-action register at 0x014 per channel
// - Four compares: reset, stop, interrupt on match
// - Stop-on-match halts counters, clears enable bit
// - Capture control at 0x028 selects edges, interrupt
// - Capture edge copies count into snapshot
// - External-output control at 0x03c drives pins
// - Count-source register at 0x070 selects mode
// - PWM register at 0x074 switches pins
// - Implemented bits reset to zero
// - Two instances differ only in base address
package timer16_pkg;
    localparam int OFF_W = 12;
    localparam logic [OFF_W-1:0] OFF_FLAGS = 12'h000;
    localparam logic [OFF_W-1:0] OFF_RUN = 12'h004;
    localparam logic [OFF_W-1:0] OFF_COUNT = 12'h008;
    localparam logic [OFF_W-1:0] OFF_DIVLIM = 12'h00c;
    localparam logic [OFF_W-1:0] OFF_DIVCNT = 12'h010;
    localparam logic [OFF_W-1:0] OFF_ACTION = 12'h014;
    localparam logic [OFF_W-1:0] OFF_CMP0 = 12'h018;
    localparam logic [OFF_W-1:0] OFF_CMP1 = 12'h01c;
    localparam logic [OFF_W-1:0] OFF_CMP2 = 12'h020;
    localparam logic [OFF_W-1:0] OFF_CMP3 = 12'h024;
    localparam logic [OFF_W-1:0] OFF_CAPCTL = 12'h028;
    localparam logic [OFF_W-1:0] OFF_SNAP = 12'h02c;
    localparam logic [OFF_W-1:0] OFF_EXTOUT = 12'h03c;
    localparam logic [OFF_W-1:0] OFF_RSV_LO = 12'h040;
    localparam logic [OFF_W-1:0] OFF_RSV_HI = 12'h06c;
    localparam logic [OFF_W-1:0] OFF_SRCSEL = 12'h070;
    localparam logic [OFF_W-1:0] OFF_PWM = 12'h074;
    localparam logic [31:0] BASE_FIRST = 32'h4000c000;
    localparam logic [31:0] BASE_SECOND = 32'h40010000;
    localparam int NUM_CMP = 4;
    localparam int FLAG_CAP_BIT = 4;
    localparam int RUN_EN_BIT = 0;
    localparam int RUN_RST_BIT = 1;
    localparam int ACT_INT = 0;
    localparam int ACT_RST = 1;
    localparam int ACT_STOP = 2;
    localparam int ACT_STRIDE = 3;
    localparam int CAP_RISE_BIT = 0;
    localparam int CAP_FALL_BIT = 1;
    localparam int CAP_INT_BIT = 2;
    localparam int EXT_CTL_LSB = 4;
    localparam logic [1:0] EXT_NOP = 2'h0;
    localparam logic [1:0] EXT_CLEAR = 2'h1;
    localparam logic [1:0] EXT_SET = 2'h2;
    localparam logic [1:0] EXT_TOGGLE = 2'h3;
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_RISE = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    localparam logic [31:0] RESET_VALUE = 32'h0;

    typedef struct packed {
        logic sel;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage : timer16_pkg

/* verilog/sync_two_flop.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            stage <= '0;
            q <= '0;
        end else begin
            stage <= d;
            q <= stage;
        end
    end
endmodule : sync_two_flop
`default_nettype wire

/* verilog/timer16_top.sv */
`timescale 1ns/1ps
`default_nettype none
module timer16_top
    import timer16_pkg::*;
#(
    parameter logic [31:0] BASE_ADDR = BASE_FIRST,
    parameter int NUM_OUTS = 3,
    parameter int COUNT_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_t regReq,
    output logic [31:0] regRdata,
    output logic regReadValid,
    input wire logic captureInput,
    output logic [NUM_OUTS-1:0] compareOutPins,
    output logic irq
);
    logic [1:0] rstPipe;
    logic rstN;
    logic capSync;
    logic capPrev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    sync_two_flop #(.WIDTH(1)) capSyncer (
        .clk(clk),
        .rstN(rstN),
        .d(captureInput),
        .q(capSync)
    );

    logic [4:0] flags, next_flags;
    logic [1:0] runCtrl, next_runCtrl;
    logic [COUNT_W-1:0] count, next_count;
    logic [COUNT_W-1:0] divLimit, next_divLimit;
    logic [COUNT_W-1:0] divCount, next_divCount;
    logic [11:0] action, next_action;
    logic [COUNT_W-1:0] cmpVal [NUM_CMP];
    logic [COUNT_W-1:0] next_cmpVal [NUM_CMP];
    logic [2:0] capCtl, next_capCtl;
    logic [COUNT_W-1:0] snapshot, next_snapshot;
    logic [11:0] extOut, next_extOut;
    logic [3:0] srcSel, next_srcSel;
    logic [3:0] pwmCtl, next_pwmCtl;
    logic [31:0] next_regRdata;
    logic [NUM_OUTS-1:0] next_pins;
    logic next_irq;

    logic hit, wr, rd;
    logic [OFF_W-1:0] off;
    logic capRise, capFall, capEvt, advance, running, tick;
    logic [NUM_CMP-1:0] match, intHit, rstHit, stopHit;

    assign hit = regReq.sel && (regReq.addr[31:OFF_W] == BASE_ADDR[31:OFF_W]);
    assign wr = hit && regReq.write;
    assign rd = hit && !regReq.write;
    assign off = regReq.addr[OFF_W-1:0];
    assign capRise = capSync && !capPrev;
    assign capFall = !capSync && capPrev;
    assign capEvt = (capCtl[CAP_RISE_BIT] && capRise)
        || (capCtl[CAP_FALL_BIT] && capFall);

    // Count source selection
    always_comb begin
        case (srcSel[1:0])
            MODE_TIMER: advance = 1'b1;
            MODE_RISE: advance = capRise;
            MODE_FALL: advance = capFall;
            MODE_BOTH: advance = capRise || capFall;
            default: advance = 1'b0;
        endcase
    end

    assign running = runCtrl[RUN_EN_BIT] && !runCtrl[RUN_RST_BIT];
    assign tick = running && advance && (divCount == divLimit);

    // Per-channel match and pin drive
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CMP; ch++) begin : g_cmp
            assign match[ch] = tick && (count == cmpVal[ch]);
            assign intHit[ch] = match[ch] && action[ch*ACT_STRIDE+ACT_INT];
            assign rstHit[ch] = match[ch] && action[ch*ACT_STRIDE+ACT_RST];
            assign stopHit[ch] = match[ch] && action[ch*ACT_STRIDE+ACT_STOP];
            if (ch < NUM_OUTS) begin : g_pin
                assign next_pins[ch] = pwmCtl[ch] ? (count >= cmpVal[ch])
                    : next_extOut[ch];
            end
        end
    endgenerate

    // Register state and counting
    always_comb begin
        next_flags = flags;
        next_runCtrl = runCtrl;
        next_count = count;
        next_divLimit = divLimit;
        next_divCount = divCount;
        next_action = action;
        next_cmpVal = cmpVal;
        next_capCtl = capCtl;
        next_snapshot = snapshot;
        next_extOut = extOut;
        next_srcSel = srcSel;
        next_pwmCtl = pwmCtl;
        if (running && advance) begin
            next_divCount = tick ? '0 : divCount + 1'b1;
        end
        if (tick) begin
            next_count = (|rstHit) ? '0 : count + 1'b1;
        end
        for (int i = 0; i < NUM_OUTS; i++) begin
            if (match[i]) begin
                case (extOut[EXT_CTL_LSB+2*i +: 2])
                    EXT_CLEAR: next_extOut[i] = 1'b0;
                    EXT_SET: next_extOut[i] = 1'b1;
                    EXT_TOGGLE: next_extOut[i] = !extOut[i];
                    default: next_extOut[i] = extOut[i];
                endcase
            end
        end
        if (wr) begin
            case (off)
                OFF_FLAGS: next_flags = flags & ~regReq.wdata[4:0];
                OFF_RUN: next_runCtrl = regReq.wdata[1:0];
                OFF_COUNT: next_count = regReq.wdata[COUNT_W-1:0];
                OFF_DIVLIM: next_divLimit = regReq.wdata[COUNT_W-1:0];
                OFF_DIVCNT: next_divCount = regReq.wdata[COUNT_W-1:0];
                OFF_ACTION: next_action = regReq.wdata[11:0];
                OFF_CMP0: next_cmpVal[0] = regReq.wdata[COUNT_W-1:0];
                OFF_CMP1: next_cmpVal[1] = regReq.wdata[COUNT_W-1:0];
                OFF_CMP2: next_cmpVal[2] = regReq.wdata[COUNT_W-1:0];
                OFF_CMP3: next_cmpVal[3] = regReq.wdata[COUNT_W-1:0];
                OFF_CAPCTL: next_capCtl = regReq.wdata[2:0];
                OFF_EXTOUT: next_extOut = regReq.wdata[11:0];
                OFF_SRCSEL: next_srcSel = regReq.wdata[3:0];
                OFF_PWM: next_pwmCtl = regReq.wdata[3:0];
                default: next_flags = next_flags;
            endcase
        end
        next_flags[NUM_CMP-1:0] = next_flags[NUM_CMP-1:0] | intHit;
        if (capEvt && capCtl[CAP_INT_BIT]) begin
            next_flags[FLAG_CAP_BIT] = 1'b1;
        end
        if (capEvt) begin
            next_snapshot = count;
        end
        if (|stopHit) begin
            next_runCtrl[RUN_EN_BIT] = 1'b0;
        end
        if (runCtrl[RUN_RST_BIT]) begin
            next_count = '0;
            next_divCount = '0;
        end
        next_irq = |next_flags;
    end

    // Read data
    always_comb begin
        next_regRdata = RESET_VALUE;
        if (rd) begin
            case (off)
                OFF_FLAGS: next_regRdata[4:0] = flags;
                OFF_RUN: next_regRdata[1:0] = runCtrl;
                OFF_COUNT: next_regRdata[COUNT_W-1:0] = count;
                OFF_DIVLIM: next_regRdata[COUNT_W-1:0] = divLimit;
                OFF_DIVCNT: next_regRdata[COUNT_W-1:0] = divCount;
                OFF_ACTION: next_regRdata[11:0] = action;
                OFF_CMP0: next_regRdata[COUNT_W-1:0] = cmpVal[0];
                OFF_CMP1: next_regRdata[COUNT_W-1:0] = cmpVal[1];
                OFF_CMP2: next_regRdata[COUNT_W-1:0] = cmpVal[2];
                OFF_CMP3: next_regRdata[COUNT_W-1:0] = cmpVal[3];
                OFF_CAPCTL: next_regRdata[2:0] = capCtl;
                OFF_SNAP: next_regRdata[COUNT_W-1:0] = snapshot;
                OFF_EXTOUT: next_regRdata[11:0] = extOut;
                OFF_SRCSEL: next_regRdata[3:0] = srcSel;
                OFF_PWM: next_regRdata[3:0] = pwmCtl;
                default: next_regRdata = RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            flags <= '0;
            runCtrl <= '0;
            count <= '0;
            divLimit <= '0;
            divCount <= '0;
            action <= '0;
            for (int i = 0; i < NUM_CMP; i++) begin
                cmpVal[i] <= '0;
            end
            capCtl <= '0;
            snapshot <= '0;
            extOut <= '0;
            srcSel <= '0;
            pwmCtl <= '0;
            capPrev <= 1'b0;
            regRdata <= '0;
            regReadValid <= 1'b0;
            compareOutPins <= '0;
            irq <= 1'b0;
        end else begin
            flags <= next_flags;
            runCtrl <= next_runCtrl;
            count <= next_count;
            divLimit <= next_divLimit;
            divCount <= next_divCount;
            action <= next_action;
            cmpVal <= next_cmpVal;
            capCtl <= next_capCtl;
            snapshot <= next_snapshot;
            extOut <= next_extOut;
            srcSel <= next_srcSel;
            pwmCtl <= next_pwmCtl;
            capPrev <= capSync;
            regRdata <= next_regRdata;
            regReadValid <= rd;
            compareOutPins <= next_pins;
            irq <= next_irq;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    logic wrCount;
    assign wrCount = wr && (off == OFF_COUNT || off == OFF_DIVCNT);

    sequence s_cmp0_int;
        tick && match[0] && action[ACT_INT];
    endsequence

    sequence s_plain_step;
        tick && !(|rstHit) && !wrCount && !runCtrl[RUN_RST_BIT];
    endsequence

    a_irq_any_flag: assert property (irq == (|flags))
        else $error("irq disagrees with flags");
    a_flag_set: assert property (s_cmp0_int |=> flags[0])
        else $error("compare 0 flag not set");
    a_flag_clear: assert property (
        wr && off == OFF_FLAGS && regReq.wdata[1] && !intHit[1]
        |=> !flags[1]) else $error("flag 1 not cleared");
    a_hold_reset: assert property (
        runCtrl[RUN_RST_BIT] |=> count == '0 && divCount == '0)
        else $error("hold reset did not zero counters");
    a_count_step: assert property (
        s_plain_step |=> count == $past(count) + 1'b1 && divCount == '0)
        else $error("count did not step on tick");
    a_stop_match: assert property (
        (|stopHit) && !wr |=> !runCtrl[RUN_EN_BIT] ##1 $stable(count))
        else $error("stop on match failed");
    a_snapshot_load: assert property (
        capEvt |=> snapshot == $past(count))
        else $error("snapshot not loaded");
    a_reserved_zero: assert property (
        rd && off >= OFF_RSV_LO && off <= OFF_RSV_HI |=> regRdata == '0)
        else $error("reserved offset read nonzero");
    a_idle_still: assert property (
        !runCtrl[RUN_EN_BIT] && !wrCount && !runCtrl[RUN_RST_BIT]
        |=> $stable(count) && $stable(divCount))
        else $error("counter moved while disabled");
endmodule : timer16_top
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import timer16_pkg::*;
    logic clk;
    logic nrst;
    reg_req_t regReq;
    logic [31:0] regRdata;
    logic regReadValid;
    logic captureInput;
    logic [2:0] compareOutPins;
    logic irq;
    int err_total;
    int compares;
    int seed;
    int n;
    int l;
    logic [31:0] rv;
    logic [31:0] rv2;
    logic [11:0] rwOff [7] = '{OFF_COUNT, OFF_DIVLIM, OFF_DIVCNT, OFF_CMP0,
        OFF_CMP1, OFF_CMP2, OFF_CMP3};

    timer16_top timer16_top_i (
        .clk(clk),
        .nrst(nrst),
        .regReq(regReq),
        .regRdata(regRdata),
        .regReadValid(regReadValid),
        .captureInput(captureInput),
        .compareOutPins(compareOutPins),
        .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] exp_quot(input int k, input int p);
        return 32'(k / p);
    endfunction : exp_quot

    function automatic logic [31:0] exp_rem(input int k, input int p);
        return 32'(k % p);
    endfunction : exp_rem

    function automatic logic [31:0] exp_edges(input int md, input int k);
        return 32'((md == int'(MODE_BOTH)) ? 2 * k : k);
    endfunction : exp_edges

    // Pin 0 set, pin 1 toggled, pin 2 preset high then cleared
    function automatic logic [31:0] ext_cfg(input int ch);
        logic [1:0] act;
        act = (ch == 1) ? EXT_TOGGLE : ((ch == 2) ? EXT_CLEAR : EXT_SET);
        return (32'(act) << (EXT_CTL_LSB + 2 * ch))
            | ((ch == 2) ? 32'h4 : 32'h0);
    endfunction : ext_cfg

    function automatic logic [31:0] pin_exp(input int ch);
        return (ch < 2) ? 32'h1 << ch : 32'h0;
    endfunction : pin_exp

    // One bus access, request held for exactly one sampling edge
    task automatic acc(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge clk);
        regReq <= '{sel: 1'b1, write: w, addr: a, wdata: d};
        @(posedge clk);
        regReq.sel <= 1'b0;
        #1;
    endtask : acc

    task automatic wr(input logic [11:0] o, input logic [31:0] d);
        acc(1'b1, {BASE_FIRST[31:12], o}, d);
    endtask : wr

    task automatic rd(input logic [11:0] o, output logic [31:0] d);
        acc(1'b0, {BASE_FIRST[31:12], o}, 32'h0);
        chk({31'h0, regReadValid}, 32'h1);
        d = regRdata;
    endtask : rd

    task automatic rdchk(input logic [11:0] o, input logic [31:0] e);
        logic [31:0] d;
        rd(o, d);
        chk(d, e);
    endtask : rdchk

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("Error at %0t: timeout", $time);
        test_done();
    end

    initial begin
        seed = 9385;
        err_total = 0;
        compares = 0;
        nrst = 1'b0;
        regReq = '0;
        captureInput = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int o = 0; o <= 'h74; o += 4) begin
            rdchk(o[11:0], 32'h0);
        end
        chk({31'h0, irq}, 32'h0);
        chk({29'h0, compareOutPins}, 32'h0);
        foreach (rwOff[i]) begin
            rv = $random(seed);
            wr(rwOff[i], rv);
            rdchk(rwOff[i], rv & 32'hffff);
        end
        // Reserved, read-only and foreign-base accesses
        wr(OFF_RSV_LO, 32'hffffffff);
        rdchk(OFF_RSV_LO, 32'h0);
        wr(OFF_SNAP, 32'h1234);
        rdchk(OFF_SNAP, 32'h0);
        wr(OFF_COUNT, 32'h0);
        acc(1'b1, BASE_SECOND + 32'(OFF_COUNT), 32'h55);
        acc(1'b0, BASE_SECOND + 32'(OFF_COUNT), 32'h0);
        chk({31'h0, regReadValid}, 32'h0);
        rdchk(OFF_COUNT, 32'h0);
        // Timer mode: count steps every limit+1 enabled edges
        for (int t = 0; t < 5; t++) begin
            l = (t == 0) ? 0 : ($random(seed) & 3);
            n = $random(seed) & 15;
            wr(OFF_DIVLIM, l);
            wr(OFF_COUNT, 32'h0);
            wr(OFF_DIVCNT, 32'h0);
            wr(OFF_RUN, 32'h1);
            repeat (n) @(posedge clk);
            wr(OFF_RUN, 32'h0);
            rdchk(OFF_COUNT, exp_quot(n + 2, l + 1));
            rdchk(OFF_DIVCNT, exp_rem(n + 2, l + 1));
        end
        // Hold reset beats software write
        wr(OFF_COUNT, 32'h77);
        wr(OFF_RUN, 32'h3);
        wr(OFF_COUNT, 32'h9);
        rdchk(OFF_COUNT, 32'h0);
        rdchk(OFF_DIVCNT, 32'h0);
        rdchk(OFF_RUN, 32'h3);
        wr(OFF_RUN, 32'h0);
        // Each channel: interrupt, reset and stop on match
        wr(OFF_DIVLIM, 32'h0);
        for (int ch = 0; ch < NUM_CMP; ch++) begin
            rv = 32'(4 + ($random(seed) & 15));
            wr(OFF_EXTOUT, 32'h0);
            wr(OFF_COUNT, 32'h0);
            wr(12'(OFF_CMP0 + 4 * ch), rv);
            wr(OFF_ACTION, 32'h7 << (ACT_STRIDE * ch));
            if (ch < 3) begin
                wr(OFF_EXTOUT, ext_cfg(ch));
                chk({29'h0, compareOutPins}, ext_cfg(ch) & 32'h7);
            end
            wr(OFF_RUN, 32'h1);
            repeat (30) @(posedge clk);
            rdchk(OFF_RUN, 32'h0);
            rdchk(OFF_COUNT, 32'h0);
            rdchk(OFF_FLAGS, 32'h1 << ch);
            chk({31'h0, irq}, 32'h1);
            chk({29'h0, compareOutPins}, pin_exp(ch));
            wr(OFF_FLAGS, 32'h0);
            rdchk(OFF_FLAGS, 32'h1 << ch);
            wr(OFF_FLAGS, 32'h1 << ch);
            rdchk(OFF_FLAGS, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Reset-only on channel 1 gives a period of compare+1
        wr(OFF_CMP1, 32'h6);
        wr(OFF_ACTION, 32'h10);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_RUN, 32'h1);
        repeat (40) @(posedge clk);
        wr(OFF_RUN, 32'h0);
        rdchk(OFF_COUNT, exp_rem(40 + 2, 6 + 1));
        rdchk(OFF_FLAGS, 32'h0);
        wr(OFF_ACTION, 32'h0);
        // PWM on pin 0
        wr(OFF_CMP0, 32'h5);
        wr(OFF_PWM, 32'h1);
        wr(OFF_COUNT, 32'ha);
        repeat (3) @(posedge clk);
        chk({31'h0, compareOutPins[0]}, 32'h1);
        wr(OFF_COUNT, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, compareOutPins[0]}, 32'h0);
        wr(OFF_PWM, 32'h0);
        // Counter modes: rising, falling, both edges
        for (int md = 1; md < 4; md++) begin
            n = 3 + ($random(seed) & 3);
            wr(OFF_SRCSEL, md);
            rdchk(OFF_SRCSEL, md);
            wr(OFF_COUNT, 32'h0);
            wr(OFF_RUN, 32'h1);
            for (int k = 0; k < n; k++) begin
                @(posedge clk) captureInput <= 1'b1;
                repeat (5) @(posedge clk);
                captureInput <= 1'b0;
                repeat (5) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            wr(OFF_RUN, 32'h0);
            rdchk(OFF_COUNT, exp_edges(md, n));
        end
        wr(OFF_SRCSEL, 32'h0);
        rdchk(OFF_SNAP, 32'h0);
        rdchk(OFF_FLAGS, 32'h0);
        // Capture on rising then falling edge, count changed between
        for (int e = 0; e < 2; e++) begin
            rv = $random(seed) & 32'hffff;
            rv2 = rv ^ 32'h5a5a;
            wr(OFF_CAPCTL, (32'h1 << e) | 32'h4);
            wr(OFF_COUNT, rv);
            @(posedge clk) captureInput <= 1'b1;
            repeat (8) @(posedge clk);
            wr(OFF_COUNT, rv2);
            @(posedge clk) captureInput <= 1'b0;
            repeat (8) @(posedge clk);
            rdchk(OFF_SNAP, (e == 0) ? rv : rv2);
            rdchk(OFF_FLAGS, 32'h10);
            chk({31'h0, irq}, 32'h1);
            wr(OFF_FLAGS, 32'h10);
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
